// *** rtl/prc_map.svh ***
// register indices, command and status codes, limits and reset values
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// register indices; byte address is four times the index
`define PRC_IDX_CMD 30'h0
`define PRC_IDX_STAT 30'ha
`define PRC_IDX_LEN 30'h2710
`define PRC_IDX_POST 30'h2774
`define PRC_IDX_ONE 30'ha028
`define PRC_IDX_LOOP 30'ha08c
`define PRC_IDX_WIDE 30'h20000
`define PRC_IDX_SETTLE 30'h20001
// command codes
`define PRC_CMD_GO 32'h0000000a
`define PRC_CMD_GO_BLOCK 32'h0000000b
`define PRC_CMD_HALT 32'h00000014
// status codes
`define PRC_STAT_ARMED 32'h00000000
`define PRC_STAT_TRIG 32'h0000000a
`define PRC_STAT_IDLE 32'h00000014
// post counter range in samples
`define PRC_POST_MAX8 32'h10000000
`define PRC_POST_MAX16 32'h08000000
// reset values
`define PRC_LEN_RST 32'h00000040
`define PRC_POST_RST 32'h00000040
`define PRC_SETTLE_RST 32'h00000000
`define PRC_ZERO 32'h00000000
`define PRC_ONE 32'h00000001
`endif

// *** rtl/prc_pkg.sv ***
// types shared by the replay control block
package prc_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_ARMED = 4'b0100,
    ST_TRIG = 4'b1000
  } prc_state_t;
  // decoded register select
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_CMD = 4'h1,
    SEL_STAT = 4'h2,
    SEL_LEN = 4'h3,
    SEL_POST = 4'h4,
    SEL_ONE = 4'h5,
    SEL_LOOP = 4'h6,
    SEL_WIDE = 4'h7,
    SEL_SETTLE = 4'h8
  } prc_sel_t;
  // whole state of the top module
  typedef struct packed {
    prc_state_t fsm;
    logic [31:0] cmd;
    logic [31:0] len;
    logic [31:0] post;
    logic one_pass;
    logic loop_out;
    logic wide;
    logic [31:0] settle;
    logic [31:0] sh_len;
    logic [31:0] sh_post;
    logic sh_one;
    logic sh_loop;
    logic irq_mode;
    logic irq;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic dph_wr;
    prc_sel_t dph_sel;
    logic [31:0] samp_addr;
    logic samp_valid;
  } prc_top_t;
endpackage

// *** rtl/prc_counter.sv ***
// wrapping sample counter with clear and terminal flag
`timescale 1ns/1ps
module prc_counter #(
  parameter int CNT_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic step,
  input wire logic [CNT_W-1:0] limit,
  output logic [CNT_W-1:0] count,
  output logic last
);
  // state of the counter
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } prc_cnt_t;
  prc_cnt_t s_r;
  prc_cnt_t s_nxt;
  // refuse widths the logic cannot serve
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_w
    $error("prc_counter: CNT_W out of range");
  end
  // terminal sample of the pass
  assign last = (s_r.cnt == limit - CNT_W'(1));
  assign count = s_r.cnt;
  // next count: clear, wrap on last, or advance
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.cnt = '0;
    end else if (step) begin
      s_nxt.cnt = last ? '0 : s_r.cnt + CNT_W'(1);
    end
  end
  // register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // prc_counter

// *** rtl/prc_settle.sv ***
// relay settling countdown, loaded on start
`timescale 1ns/1ps
module prc_settle #(
  parameter int CNT_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [CNT_W-1:0] cycles,
  output logic done
);
  // state of the countdown
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } prc_set_t;
  prc_set_t s_r;
  prc_set_t s_nxt;
  // refuse widths the logic cannot serve
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_w
    $error("prc_settle: CNT_W out of range");
  end
  // interval has elapsed
  assign done = (s_r.cnt == '0);
  // load on start, then count down to zero
  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = cycles;
    end else if (!done) begin
      s_nxt.cnt = s_r.cnt - CNT_W'(1);
    end
  end
  // register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // prc_settle

// *** rtl/prc_top.sv ***
// pattern replay sequencer with its ahb-lite register slave
`timescale 1ns/1ps
`include "prc_map.svh"
// What this block does
// - holds replay length in samples per channel
// - holds post-trigger sample count
// - post count capped 256M or 128M
// - command 10 starts with current settings
// - start latches setup, then runs
// - wait settling interval before output
// - command 20 stops at once, any state
// - runs alone until finished or stopped
// - status 0 armed, 10 triggered, 20 stopped
// - returns to ready by itself on completion
// - status read-only, readable any time
// - interrupt on stop in interrupt mode
// - command 11 starts in interrupt mode
// - single shot plays length once after trigger
// - continuous wraps without gap until stopped
// - post mode loops, then plays post count
module prc_top
  import prc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic trig_in,
  output logic [31:0] samp_addr,
  output logic samp_valid,
  output logic done_irq
);
  prc_top_t s_r; // registered state
  prc_top_t s_nxt; // next state
  logic aph; // valid address phase this cycle
  prc_sel_t aph_sel; // register picked by the address
  logic wr_cmd; // command write in data phase
  logic go_ok; // accepted start
  logic halt; // stop command
  logic post_mode; // neither single shot nor continuous
  logic stream; // a sample goes out this cycle
  logic post_step; // counts samples after the trigger
  logic [31:0] addr_cnt; // sample position
  logic addr_last; // last sample of the pattern
  logic post_last; // last sample after trigger
  logic settle_done; // relay interval elapsed
  logic finish; // replay completed on its own
  logic [31:0] post_lim; // post counter ceiling

  // map a byte address to a register select
  function automatic prc_sel_t decode(input logic [31:0] a);
    prc_sel_t r;
    r = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[31:2])
        `PRC_IDX_CMD: r = SEL_CMD;
        `PRC_IDX_STAT: r = SEL_STAT;
        `PRC_IDX_LEN: r = SEL_LEN;
        `PRC_IDX_POST: r = SEL_POST;
        `PRC_IDX_ONE: r = SEL_ONE;
        `PRC_IDX_LOOP: r = SEL_LOOP;
        `PRC_IDX_WIDE: r = SEL_WIDE;
        `PRC_IDX_SETTLE: r = SEL_SETTLE;
        default: r = SEL_NONE;
      endcase
    end
    return r;
  endfunction

  // status code for the current state
  function automatic logic [31:0] stat_code(input prc_state_t f);
    logic [31:0] r;
    r = `PRC_STAT_IDLE;
    if (f == ST_SETTLE || f == ST_ARMED) begin
      r = `PRC_STAT_ARMED;
    end else if (f == ST_TRIG) begin
      r = `PRC_STAT_TRIG;
    end
    return r;
  endfunction

  // bus decode and command qualifiers
  assign aph = hsel && htrans[1] && hready;
  assign aph_sel = decode(haddr);
  assign wr_cmd = s_r.dph_wr && (s_r.dph_sel == SEL_CMD);
  assign halt = wr_cmd && (hwdata == `PRC_CMD_HALT);
  // a start counts only from idle
  assign go_ok = wr_cmd && (s_r.fsm == ST_IDLE) &&
    ((hwdata == `PRC_CMD_GO) || (hwdata == `PRC_CMD_GO_BLOCK));
  assign post_mode = !s_r.sh_one && !s_r.sh_loop;
  // post mode loops already while armed
  assign stream = (s_r.fsm == ST_TRIG) ||
    ((s_r.fsm == ST_ARMED) && post_mode);
  assign post_step = (s_r.fsm == ST_TRIG) && post_mode;
  assign post_lim = s_r.wide ? `PRC_POST_MAX16 : `PRC_POST_MAX8;
  // completion: single shot at pattern end, post mode at count
  assign finish = (s_r.fsm == ST_TRIG) &&
    ((s_r.sh_one && addr_last) || (post_step && post_last));

  // pattern position, wraps with no gap
  prc_counter #(
    .CNT_W(32)
  ) u_addr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(go_ok),
    .step(stream),
    .limit(s_r.sh_len),
    .count(addr_cnt),
    .last(addr_last)
  );

  // samples played since the trigger
  prc_counter #(
    .CNT_W(32)
  ) u_post (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(go_ok),
    .step(post_step),
    .limit(s_r.sh_post),
    .count(),
    .last(post_last)
  );

  // relay settling interval after start
  prc_settle #(
    .CNT_W(32)
  ) u_settle (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(go_ok),
    .cycles(s_r.settle),
    .done(settle_done)
  );

  // next state: bus slave, setup registers and sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.hready = 1'b1;
    s_nxt.hresp = 1'b0;
    // address phase: remember write target, fetch read data
    s_nxt.dph_wr = aph && hwrite;
    s_nxt.dph_sel = aph ? aph_sel : SEL_NONE;
    if (aph && !hwrite) begin
      unique case (aph_sel)
        SEL_CMD: s_nxt.hrdata = s_r.cmd;
        SEL_STAT: s_nxt.hrdata = stat_code(s_r.fsm);
        SEL_LEN: s_nxt.hrdata = s_r.len;
        SEL_POST: s_nxt.hrdata = s_r.post;
        SEL_ONE: s_nxt.hrdata = {31'h0, s_r.one_pass};
        SEL_LOOP: s_nxt.hrdata = {31'h0, s_r.loop_out};
        SEL_WIDE: s_nxt.hrdata = {31'h0, s_r.wide};
        SEL_SETTLE: s_nxt.hrdata = s_r.settle;
        SEL_NONE: s_nxt.hrdata = `PRC_ZERO;
      endcase
    end
    // reading the status acknowledges the interrupt
    if (aph && !hwrite && aph_sel == SEL_STAT) begin
      s_nxt.irq = 1'b0;
    end
    // data phase writes; the status register takes none
    if (s_r.dph_wr) begin
      unique case (s_r.dph_sel)
        SEL_CMD: s_nxt.cmd = hwdata;
        SEL_LEN: s_nxt.len = hwdata;
        SEL_POST: s_nxt.post = hwdata;
        SEL_ONE: s_nxt.one_pass = hwdata[0];
        SEL_LOOP: s_nxt.loop_out = hwdata[0];
        SEL_WIDE: s_nxt.wide = hwdata[0];
        SEL_SETTLE: s_nxt.settle = hwdata;
        SEL_STAT, SEL_NONE: s_nxt.cmd = s_r.cmd;
      endcase
    end
    // sequencer, running without the host once started
    unique case (s_r.fsm)
      ST_IDLE: begin
        if (go_ok) begin
          // take over the setup, then begin
          s_nxt.sh_len = (s_r.len == `PRC_ZERO) ? `PRC_ONE : s_r.len;
          s_nxt.sh_post = (s_r.post > post_lim) ? post_lim :
            s_r.post;
          s_nxt.sh_one = s_r.one_pass;
          s_nxt.sh_loop = s_r.loop_out;
          // blocking start completes by interrupt
          s_nxt.irq_mode = (hwdata == `PRC_CMD_GO_BLOCK);
          s_nxt.irq = 1'b0;
          s_nxt.fsm = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // hold output until relays have settled
        if (settle_done) begin
          s_nxt.fsm = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // wait for the trigger event
        if (trig_in) begin
          s_nxt.fsm = ST_TRIG;
        end
      end
      ST_TRIG: begin
        // single shot and post mode end alone
        if (finish) begin
          s_nxt.fsm = ST_IDLE;
        end
      end
    endcase
    // stop from any state overrides everything
    if (halt) begin
      s_nxt.fsm = ST_IDLE;
    end
    // stop event raises the interrupt; set beats clear
    if (s_r.irq_mode && s_r.fsm != ST_IDLE &&
        s_nxt.fsm == ST_IDLE) begin
      s_nxt.irq = 1'b1;
    end
    // sample stream towards the pattern memory
    s_nxt.samp_addr = addr_cnt;
    s_nxt.samp_valid = stream;
  end

  // register the whole state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.len <= `PRC_LEN_RST;
      s_r.post <= `PRC_POST_RST;
      s_r.settle <= `PRC_SETTLE_RST;
      s_r.sh_len <= `PRC_LEN_RST;
      s_r.sh_post <= `PRC_POST_RST;
      s_r.hready <= 1'b1;
      s_r.dph_sel <= SEL_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hready;
  assign hresp = s_r.hresp;
  assign samp_addr = s_r.samp_addr;
  assign samp_valid = s_r.samp_valid;
  assign done_irq = s_r.irq;

  // a stop command leaves the block idle one edge later
  AST_HALT_IDLE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    halt |=> (s_r.fsm == ST_IDLE) ##1 !samp_valid)
    else $error("stop command did not stop the block");

  // a start from idle enters settling with the setup taken over
  AST_GO_LATCH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (go_ok && !halt) |=> (s_r.fsm == ST_SETTLE) &&
      (s_r.sh_one == $past(s_r.one_pass)) &&
      (s_r.sh_loop == $past(s_r.loop_out)))
    else $error("start did not take over the setup");

  // command 10 starts in polled mode, 11 in interrupt mode
  AST_GO_MODE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    go_ok |=> s_r.irq_mode == ($past(hwdata) == `PRC_CMD_GO_BLOCK))
    else $error("start command took the wrong mode");

  // a command 10 while armed or triggered leaves state and latched length unchanged
  AST_GO_IGNORED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_cmd && hwdata == `PRC_CMD_GO && !finish &&
      ((s_r.fsm == ST_ARMED && !trig_in) || s_r.fsm == ST_TRIG)) |=>
      $stable(s_r.fsm) && $stable(s_r.sh_len))
    else $error("start while running disturbed the block");

  // status read returns the code of the state it was taken in
  AST_STAT_CODE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph && !hwrite && aph_sel == SEL_STAT) |=>
      hrdata == (($past(s_r.fsm) == ST_TRIG) ? `PRC_STAT_TRIG :
      ($past(s_r.fsm) == ST_IDLE) ? `PRC_STAT_IDLE :
      `PRC_STAT_ARMED))
    else $error("status read returned the wrong code");

  // the slave never stalls a status poll
  AST_ALWAYS_READY: assert property (
    @(posedge hclk) disable iff (!hresetn)
    aph |=> hreadyout && !hresp)
    else $error("slave stalled or erred");

  // no output before the settling interval has elapsed
  AST_SETTLE_HOLD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.fsm == ST_SETTLE && !settle_done && !halt) |=>
      (s_r.fsm == ST_SETTLE) && !samp_valid)
    else $error("left settling too early");

  // single shot returns to ready after the last sample
  AST_ONE_PASS_END: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.fsm == ST_TRIG && s_r.sh_one && addr_last) |=>
      s_r.fsm == ST_IDLE ##1 !samp_valid)
    else $error("single shot did not finish");

  // continuous output wraps to sample zero and keeps running
  AST_WRAP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.fsm == ST_TRIG && s_r.sh_loop && !s_r.sh_one &&
      addr_last && !halt) |=> (addr_cnt == `PRC_ZERO) &&
      (s_r.fsm == ST_TRIG) ##1 samp_valid)
    else $error("continuous output did not wrap");

  // post mode ends on the post count after the trigger
  AST_POST_END: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (post_step && post_last) |=> s_r.fsm == ST_IDLE)
    else $error("post mode did not finish on count");

  // latched post count stays inside the counter range of its width
  AST_POST_RANGE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    go_ok |=> s_r.sh_post <= ($past(s_r.wide) ? `PRC_POST_MAX16 :
      `PRC_POST_MAX8))
    else $error("post count beyond range");

  // an interrupt-mode stop raises the interrupt
  AST_IRQ_ON_STOP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.irq_mode && s_r.fsm != ST_IDLE && halt) |=> done_irq)
    else $error("stop gave no interrupt");
endmodule // prc_top

// *** verification/prc_host.sv ***
// host model: ahb-lite master with register programming sequences
`timescale 1ns/1ps
`include "prc_map.svh"
module prc_host #(
  parameter int MEM_SAMPLES = 4096
) (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic done_irq,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic res_valid,
  output logic [31:0] res_data
);
  // bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    res_valid = 1'b0;
    res_data = 32'h00000000;
  end
  // read result flag lasts one cycle
  always @(posedge hclk) begin
    if (res_valid) begin
      res_valid <= 1'b0;
    end
  end
  // byte address of a register index
  function automatic logic [31:0] ba(input logic [29:0] idx);
    return {idx, 2'b00};
  endfunction
  // one word transfer; each phase held until hready is seen high
  task automatic xfer(input logic wr_en, input logic [31:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr_en;
    hsize <= 3'h2;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    if (!wr_en) begin
      res_data <= hrdata;
      res_valid <= 1'b1;
    end
  endtask
  // register write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // register read, result shown on res_data
  task automatic rd(input logic [31:0] a);
    xfer(1'b0, a, ~hwdata);
  endtask
  // clamps a count to the memory or counter range and to the step
  function automatic logic [31:0] legal(input logic [31:0] n,
      input logic wide, input logic post);
    logic [31:0] st;
    logic [31:0] mx;
    st = wide ? 32'h00000020 : 32'h00000040;
    if (post) begin
      mx = wide ? `PRC_POST_MAX16 : `PRC_POST_MAX8;
    end else begin
      mx = wide ? 32'(MEM_SAMPLES / 2) : 32'(MEM_SAMPLES);
    end
    if (n > mx) n = mx;
    n = n - (n % st);
    if (n < st) n = st;
    return n;
  endfunction
  // programs the whole setup, then issues the start code
  task automatic setup_go(input logic [31:0] len, input logic [31:0] post,
      input logic one, input logic loop, input logic wide,
      input logic [31:0] settle, input logic [31:0] code);
    wr(ba(`PRC_IDX_LEN), legal(len, wide, 1'b0));
    wr(ba(`PRC_IDX_POST), legal(post, wide, 1'b1));
    wr(ba(`PRC_IDX_ONE), {31'h0, one});
    wr(ba(`PRC_IDX_LOOP), {31'h0, loop});
    wr(ba(`PRC_IDX_WIDE), {31'h0, wide});
    wr(ba(`PRC_IDX_SETTLE), settle);
    wr(ba(`PRC_IDX_CMD), code);
  endtask
  // blocking start: waits for the stop interrupt, bounded
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (done_irq !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
endmodule // prc_host

// *** verification/tb_pattern_replay_control.sv ***
// self-checking bench for the pattern replay control block
`timescale 1ns/1ps
`include "prc_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); \
  end end
module tb_pattern_replay_control;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic trig_in;
  logic [31:0] samp_addr;
  logic samp_valid;
  logic done_irq;
  logic res_valid;
  logic [31:0] res_data;
  int miscompares = 0;
  int total_checks = 0;
  int cnt;
  logic [31:0] exp_q[$];
  logic [31:0] exp_w;
  logic [31:0] rnd = 32'hfb2a3d72;
  logic [31:0] v;
  // clock, 10 ns period
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // single slave: its hreadyout is the bus hready
  prc_top prc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
    .samp_addr(samp_addr), .samp_valid(samp_valid), .done_irq(done_irq));
  // host driver on the register bus
  prc_host #(.MEM_SAMPLES(4096)) prc_host_inst (.hclk(hclk),
    .hready(hreadyout), .hrdata(hrdata), .done_irq(done_irq), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .res_valid(res_valid), .res_data(res_data));
  // watcher: each read result is matched with the oldest note
  always @(posedge hclk) begin
    if (res_valid === 1'b1 && exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      `CHK(res_data, exp_w)
      `CHK(hresp, 1'b0)
    end
  end
  // byte address of a register index
  function automatic logic [31:0] ba(input logic [29:0] idx);
    return {idx, 2'b00};
  endfunction
  // pseudo random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // notes the expected value, then reads
  task automatic rd_chk(input logic [29:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    prc_host_inst.rd(ba(idx));
  endtask
  // pulses the trigger after wait_c cycles and counts the samples after it
  task automatic trig_count(input int wait_c, input logic [31:0] len,
      input int lim, input logic chk_addr);
    repeat (wait_c) @(posedge hclk);
    trig_in <= 1'b1;
    @(posedge hclk);
    trig_in <= 1'b0;
    @(posedge hclk);
    @(posedge hclk);
    cnt = 0;
    while (samp_valid === 1'b1 && cnt < lim) begin
      if (chk_addr) `CHK(samp_addr, 32'(cnt) % len)
      cnt++;
      @(posedge hclk);
    end
  endtask
  // prints the counts and the verdict, then ends the run
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (50000) @(posedge hclk);
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial begin
    hresetn = 1'b0;
    trig_in = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped place, read-only status
    rd_chk(`PRC_IDX_CMD, `PRC_ZERO);
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    rd_chk(`PRC_IDX_LEN, `PRC_LEN_RST);
    rd_chk(`PRC_IDX_POST, `PRC_POST_RST);
    rd_chk(30'h40, `PRC_ZERO);
    prc_host_inst.wr(ba(`PRC_IDX_STAT), `PRC_ZERO);
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    // random lengths and counts read back
    repeat (4) begin
      rnd = lfsr_next(rnd);
      v = {20'h0, rnd[5:0], 6'h0} + 32'h40;
      prc_host_inst.wr(ba(`PRC_IDX_LEN), v);
      rd_chk(`PRC_IDX_LEN, v);
      prc_host_inst.wr(ba(`PRC_IDX_POST), v ^ 32'h00000fc0);
      rd_chk(`PRC_IDX_POST, v ^ 32'h00000fc0);
    end
    // single shot; setup latched at start, length changed meanwhile
    v = {24'h0, rnd[9:8], 6'h0} + 32'h40;
    prc_host_inst.setup_go(v, 32'h40, 1'b1, 1'b0, 1'b0, 32'h3,
      `PRC_CMD_GO);
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_ARMED);
    prc_host_inst.wr(ba(`PRC_IDX_LEN), 32'h00000200);
    trig_count(1, v, 600, 1'b1);
    `CHK(32'(cnt), v)
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    `CHK(done_irq, 1'b0)
    rd_chk(`PRC_IDX_ONE, `PRC_ONE);
    // continuous wrap, start ignored while running, stop
    prc_host_inst.setup_go(32'h40, 32'h40, 1'b0, 1'b1, 1'b0, 32'h0,
      `PRC_CMD_GO);
    trig_count(2, 32'h40, 150, 1'b1);
    `CHK(cnt, 150)
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_TRIG);
    prc_host_inst.wr(ba(`PRC_IDX_CMD), `PRC_CMD_GO);
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_TRIG);
    prc_host_inst.wr(ba(`PRC_IDX_CMD), `PRC_CMD_HALT);
    repeat (2) @(posedge hclk);
    `CHK(samp_valid, 1'b0)
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    rd_chk(`PRC_IDX_LOOP, `PRC_ONE);
    rd_chk(`PRC_IDX_CMD, `PRC_CMD_HALT);
    // post mode at 16-bit width with a settling wait
    prc_host_inst.setup_go(32'h40, 32'h20, 1'b0, 1'b0, 1'b1, 32'h4,
      `PRC_CMD_GO);
    repeat (5) begin
      @(posedge hclk);
      `CHK(samp_valid, 1'b0)
    end
    trig_count(1, 32'h40, 400, 1'b0);
    `CHK(cnt, 32)
    rd_chk(`PRC_IDX_WIDE, `PRC_ONE);
    rd_chk(`PRC_IDX_SETTLE, 32'h00000004);
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    // interrupt start: completion raises and a status read clears
    prc_host_inst.setup_go(32'h40, 32'h40, 1'b1, 1'b0, 1'b0, 32'h0,
      `PRC_CMD_GO_BLOCK);
    trig_count(2, 32'h40, 200, 1'b1);
    `CHK(cnt, 64)
    prc_host_inst.wait_irq(20);
    `CHK(done_irq, 1'b1)
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    @(posedge hclk);
    `CHK(done_irq, 1'b0)
    // interrupt start ended by stop before any trigger
    prc_host_inst.setup_go(32'h40, 32'h40, 1'b1, 1'b0, 1'b0, 32'h0,
      `PRC_CMD_GO_BLOCK);
    prc_host_inst.wr(ba(`PRC_IDX_CMD), `PRC_CMD_HALT);
    prc_host_inst.wait_irq(20);
    `CHK(done_irq, 1'b1)
    rd_chk(`PRC_IDX_STAT, `PRC_STAT_IDLE);
    repeat (4) @(posedge hclk);
    end_of_test();
  end
endmodule // tb_pattern_replay_control
